// ---- shared/srp_pkg.sv ----
// Constants, register layout and state type for the status/readback/idle-power register.
// Assumes a single core clock domain; all pin levels are synchronised before use.
//
// How it works
// - Register at address 0xA is 16 bits, resets to 0x0010, reached over serial port.
// - Bit 10 shows clock ready; multi-function pin mirrors it when so configured.
// - Bit 8 reads back the present level of the multi-function pin.
// - Bit 7 reads the select1/data pin, bit 6 the select0/clock pin.
// - Bit 5 reads the present level of the address strap pin.
// - Idle select 0 with all outputs disabled: mute outputs and enter low power.
// - Idle select 1 with all outputs disabled: mute only, stay running; reset default.
// - Idle select is loaded from the fuse store as its initial value.
// - Resample-disable 0: leaving low power resamples strap and both select pins.
// - After resample with strap high, device switches into fuse-configuration mode.
// - Resample-disable 1: no resample on low-power exit, stay in serial mode.
// - Writing 1 to power-down bit 1 places the device into low power.

package srp_pkg;

  // --------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------
  localparam logic [7:0] SRP_REG_ADDR = 8'h0a;
  localparam logic [15:0] SRP_REG_RESET = 16'h0010;
  localparam logic [6:0] SRP_DEV_ADDR_RESET = 7'h68;

  localparam int SRP_BIT_RSVD15 = 15;
  localparam int SRP_BIT_CLK_READY = 10;
  localparam int SRP_BIT_RSVD9 = 9;
  localparam int SRP_BIT_MFP = 8;
  localparam int SRP_BIT_SEL1 = 7;
  localparam int SRP_BIT_SEL0 = 6;
  localparam int SRP_BIT_STRAP = 5;
  localparam int SRP_BIT_IDLE = 4;
  localparam int SRP_BIT_RSD = 3;
  localparam int SRP_BIT_PDN = 1;

  // --------------------------------------------------------------
  // Pin synchroniser lanes
  // --------------------------------------------------------------
  localparam int SRP_NSYNC = 4;
  localparam int SRP_SYNC_SCL = 0;
  localparam int SRP_SYNC_SDA = 1;
  localparam int SRP_SYNC_MFP = 2;
  localparam int SRP_SYNC_STRAP = 3;

  localparam logic [3:0] SRP_BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] SRP_LAST_TX_BIT = 4'h7;

  typedef enum logic [2:0] {SRP_IDLE, SRP_RX, SRP_ACK, SRP_TX, SRP_RACK} srp_state_t;

endpackage

// ---- shared/srp_reg_if.sv ----
// Internal register access carrier between the serial front end and the register bank.
// Assumes both ends run on the same core clock.
`timescale 1ns/100ps
`default_nettype none

interface srp_reg_if;
  logic wr_stb;
  logic [15:0] wr_data;
  logic [15:0] rd_data;

  modport bus (output wr_stb, output wr_data, input rd_data);
  modport bank (input wr_stb, input wr_data, output rd_data);
endinterface

`default_nettype wire

// ---- rtl/srp_status_bank.sv ----
// Status, readback and idle-power register with low-power exit resampling.
// Assumes pin levels arrive already synchronised to core_clk.
`timescale 1ns/100ps
`default_nettype none

module srp_status_bank
  import srp_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  srp_reg_if.bank regs,
  input wire logic mfp_lvl,
  input wire logic sel1_lvl,
  input wire logic sel0_lvl,
  input wire logic strap_lvl,
  input wire logic clk_ready,
  input wire logic all_outputs_disabled,
  input wire logic fuse_idle_select,
  output logic outputs_mute,
  output logic low_power,
  output logic fuse_config_mode,
  output logic [1:0] resampled_select
);

  logic idle_ff;
  logic rsd_ff;
  logic pdn_ff;
  logic loaded_ff;
  logic lp_ff;
  logic mute_ff;
  logic mode_ff;
  logic [1:0] sel_ff;
  logic nxt_lp;
  logic lp_exit;
  logic do_resample;

  // ------------------------------------------------------------
  // Idle and power state
  // ------------------------------------------------------------
  assign nxt_lp = pdn_ff | (all_outputs_disabled & ~idle_ff);
  assign lp_exit = lp_ff & ~nxt_lp;
  assign do_resample = lp_exit & ~rsd_ff;

  // Only idle select, resample disable and power down are writable
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      idle_ff <= SRP_REG_RESET[SRP_BIT_IDLE];
      rsd_ff <= SRP_REG_RESET[SRP_BIT_RSD];
      pdn_ff <= SRP_REG_RESET[SRP_BIT_PDN];
      loaded_ff <= 1'b0;
    end
    else if (regs.wr_stb)
    begin
      idle_ff <= regs.wr_data[SRP_BIT_IDLE];
      rsd_ff <= regs.wr_data[SRP_BIT_RSD];
      pdn_ff <= regs.wr_data[SRP_BIT_PDN];
      loaded_ff <= 1'b1;
    end
    else if (!loaded_ff)
    begin
      // Fuse value is taken once, on the first edge after reset release
      idle_ff <= fuse_idle_select;
      loaded_ff <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lp_ff <= 1'b0;
      mute_ff <= 1'b0;
      mode_ff <= 1'b0;
      sel_ff <= 2'h0;
    end
    else
    begin
      lp_ff <= nxt_lp;
      mute_ff <= all_outputs_disabled;
      if (do_resample)
      begin
        mode_ff <= strap_lvl;
        sel_ff <= {sel1_lvl, sel0_lvl};
      end
    end
  end

  // Reserved and revision bits read as zero
  assign regs.rd_data = {1'b0, 4'h0, clk_ready, 1'b0, mfp_lvl, sel1_lvl, sel0_lvl,
                         strap_lvl, idle_ff, rsd_ff, 1'b0, pdn_ff, 1'b0};

  assign outputs_mute = mute_ff;
  assign low_power = lp_ff;
  assign fuse_config_mode = mode_ff;
  assign resampled_select = sel_ff;

endmodule

`default_nettype wire

// ---- rtl/srp_i2c_status_top.sv ----
// Serial-configured status/readback/idle-power register block, top level.
// Assumes the serial clock is slow against core_clk (160 ns vs 20 ns) and is sampled.
`timescale 1ns/100ps
`default_nettype none

module srp_i2c_status_top
  import srp_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = SRP_DEV_ADDR_RESET
)
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic scl_pin,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic mfp_in,
  output logic mfp_out,
  output logic mfp_oe_n,
  input wire logic mfp_ready_cfg,
  input wire logic addr_strap_pin,
  input wire logic clk_ready,
  input wire logic all_outputs_disabled,
  input wire logic fuse_idle_select,
  output logic outputs_mute,
  output logic low_power,
  output logic fuse_config_mode,
  output logic [1:0] resampled_select
);

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [SRP_NSYNC-1:0] pin_raw;
  logic [SRP_NSYNC-1:0] pin_sync;

  assign pin_raw = {addr_strap_pin, mfp_in, sda_in, scl_pin};

  genvar gi;
  generate
    for (gi = 0; gi < SRP_NSYNC; gi++)
    begin : g_sync
      logic meta_ff;
      logic sync_ff;
      always_ff @(posedge core_clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          meta_ff <= 1'b1;
          sync_ff <= 1'b1;
        end
        else
        begin
          meta_ff <= pin_raw[gi];
          sync_ff <= meta_ff;
        end
      end
      assign pin_sync[gi] = sync_ff;
    end
  endgenerate

  // ------------------------------------------------------------
  // Bus condition detection
  // ------------------------------------------------------------
  logic scl_dly_ff;
  logic sda_dly_ff;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  assign scl_s = pin_sync[SRP_SYNC_SCL];
  assign sda_s = pin_sync[SRP_SYNC_SDA];
  assign scl_rise = scl_s & ~scl_dly_ff;
  assign scl_fall = ~scl_s & scl_dly_ff;
  assign bus_start = scl_s & scl_dly_ff & ~sda_s & sda_dly_ff;
  assign bus_stop = scl_s & scl_dly_ff & sda_s & ~sda_dly_ff;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scl_dly_ff <= 1'b1;
      sda_dly_ff <= 1'b1;
    end
    else
    begin
      scl_dly_ff <= scl_s;
      sda_dly_ff <= sda_s;
    end
  end

  // ------------------------------------------------------------
  // Serial slave engine
  // ------------------------------------------------------------
  srp_reg_if regs ();

  srp_state_t state_ff;
  srp_state_t nxt_state;
  logic [3:0] bitcnt_ff;
  logic [3:0] nxt_bitcnt;
  logic [7:0] shift_ff;
  logic [7:0] nxt_shift;
  logic [1:0] idx_ff;
  logic [1:0] nxt_idx;
  logic [7:0] ptr_ff;
  logic [7:0] nxt_ptr;
  logic [7:0] hold_ff;
  logic [7:0] nxt_hold;
  logic lo_sent_ff;
  logic nxt_lo_sent;
  logic ack_ff;
  logic nxt_ack;
  logic oe_n_ff;
  logic nxt_oe_n;
  logic wr_stb_ff;
  logic nxt_wr_stb;
  logic [15:0] wr_data_ff;
  logic [15:0] nxt_wr_data;
  logic ptr_hit;
  logic addr_hit;
  logic [15:0] rd_word;

  assign ptr_hit = (ptr_ff == SRP_REG_ADDR);
  assign addr_hit = (shift_ff[7:1] == DEV_ADDR);
  // Other register addresses read zero and swallow writes
  assign rd_word = ptr_hit ? regs.rd_data : 16'h0000;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_bitcnt = bitcnt_ff;
    nxt_shift = shift_ff;
    nxt_idx = idx_ff;
    nxt_ptr = ptr_ff;
    nxt_hold = hold_ff;
    nxt_lo_sent = lo_sent_ff;
    nxt_ack = ack_ff;
    nxt_oe_n = oe_n_ff;
    nxt_wr_stb = 1'b0;
    nxt_wr_data = wr_data_ff;
    if (bus_stop)
    begin
      nxt_state = SRP_IDLE;
      nxt_oe_n = 1'b1;
    end
    else if (bus_start)
    begin
      // Repeated start restarts the address phase but keeps the pointer
      nxt_state = SRP_RX;
      nxt_bitcnt = 4'h0;
      nxt_idx = 2'h0;
      nxt_oe_n = 1'b1;
    end
    else
    begin
      case (state_ff)
        SRP_RX:
        begin
          if (scl_rise && (bitcnt_ff < SRP_BITS_PER_BYTE))
          begin
            nxt_shift = {shift_ff[6:0], sda_s};
            nxt_bitcnt = bitcnt_ff + 4'h1;
          end
          else if (scl_fall && (bitcnt_ff == SRP_BITS_PER_BYTE))
          begin
            if ((idx_ff == 2'h0) && !addr_hit)
            begin
              nxt_state = SRP_IDLE;
            end
            else
            begin
              nxt_state = SRP_ACK;
              nxt_oe_n = 1'b0;
            end
          end
        end
        SRP_ACK:
        begin
          if (scl_fall)
          begin
            nxt_oe_n = 1'b1;
            nxt_bitcnt = 4'h0;
            nxt_state = SRP_RX;
            case (idx_ff)
              2'h0:
              begin
                if (shift_ff[0])
                begin
                  // Word is snapshotted so both bytes come from one instant
                  nxt_state = SRP_TX;
                  nxt_shift = rd_word[15:8];
                  nxt_hold = rd_word[7:0];
                  nxt_lo_sent = 1'b0;
                  nxt_oe_n = rd_word[15];
                end
                else
                begin
                  nxt_idx = 2'h1;
                end
              end
              2'h1:
              begin
                nxt_ptr = shift_ff;
                nxt_idx = 2'h2;
              end
              2'h2:
              begin
                nxt_hold = shift_ff;
                nxt_idx = 2'h3;
              end
              default:
              begin
                nxt_wr_stb = ptr_hit;
                nxt_wr_data = {hold_ff, shift_ff};
                nxt_idx = 2'h2;
              end
            endcase
          end
        end
        SRP_TX:
        begin
          if (scl_fall)
          begin
            if (bitcnt_ff == SRP_LAST_TX_BIT)
            begin
              nxt_oe_n = 1'b1;
              nxt_state = SRP_RACK;
            end
            else
            begin
              nxt_bitcnt = bitcnt_ff + 4'h1;
              nxt_shift = {shift_ff[6:0], 1'b0};
              nxt_oe_n = shift_ff[6];
            end
          end
        end
        SRP_RACK:
        begin
          if (scl_rise)
          begin
            nxt_ack = ~sda_s;
          end
          else if (scl_fall)
          begin
            if (ack_ff)
            begin
              nxt_state = SRP_TX;
              nxt_bitcnt = 4'h0;
              nxt_shift = lo_sent_ff ? 8'h00 : hold_ff;
              nxt_lo_sent = 1'b1;
              nxt_oe_n = nxt_shift[7];
            end
            else
            begin
              nxt_state = SRP_IDLE;
            end
          end
        end
        default:
        begin
          nxt_state = SRP_IDLE;
          nxt_oe_n = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_ff <= SRP_IDLE;
      bitcnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      idx_ff <= 2'h0;
      ptr_ff <= 8'h00;
      hold_ff <= 8'h00;
      lo_sent_ff <= 1'b0;
      ack_ff <= 1'b0;
      oe_n_ff <= 1'b1;
      wr_stb_ff <= 1'b0;
      wr_data_ff <= 16'h0000;
    end
    else
    begin
      state_ff <= nxt_state;
      bitcnt_ff <= nxt_bitcnt;
      shift_ff <= nxt_shift;
      idx_ff <= nxt_idx;
      ptr_ff <= nxt_ptr;
      hold_ff <= nxt_hold;
      lo_sent_ff <= nxt_lo_sent;
      ack_ff <= nxt_ack;
      oe_n_ff <= nxt_oe_n;
      wr_stb_ff <= nxt_wr_stb;
      wr_data_ff <= nxt_wr_data;
    end
  end

  assign regs.wr_stb = wr_stb_ff;
  assign regs.wr_data = wr_data_ff;
  // Open drain: only ever pulls low, the enable carries the data
  assign sda_out = 1'b0;
  assign sda_oe_n = oe_n_ff;

  // ------------------------------------------------------------
  // Clock-ready mirror on the multi-function pin
  // ------------------------------------------------------------
  logic mfp_out_ff;
  logic mfp_oe_n_ff;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mfp_out_ff <= 1'b0;
      mfp_oe_n_ff <= 1'b1;
    end
    else
    begin
      mfp_out_ff <= clk_ready;
      mfp_oe_n_ff <= ~mfp_ready_cfg;
    end
  end

  assign mfp_out = mfp_out_ff;
  assign mfp_oe_n = mfp_oe_n_ff;

  // ------------------------------------------------------------
  // Register bank
  // ------------------------------------------------------------
  srp_status_bank u_bank (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .regs(regs.bank),
    .mfp_lvl(pin_sync[SRP_SYNC_MFP]),
    .sel1_lvl(sda_s),
    .sel0_lvl(scl_s),
    .strap_lvl(pin_sync[SRP_SYNC_STRAP]),
    .clk_ready(clk_ready),
    .all_outputs_disabled(all_outputs_disabled),
    .fuse_idle_select(fuse_idle_select),
    .outputs_mute(outputs_mute),
    .low_power(low_power),
    .fuse_config_mode(fuse_config_mode),
    .resampled_select(resampled_select)
  );

endmodule

`default_nettype wire

// ---- sim/srp_i2c_host.sv ----
// I2C host model driving the serial pins of the status register block.
// Assumes the testbench resolves the open-drain data wire with a pull-up.
`timescale 1ns/100ps
`default_nettype none

module srp_i2c_host
(
  input wire logic core_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_rel
);
  int naks;
  initial
  begin
    scl = 1'b1;
    sda_rel = 1'b1;
    naks = 0;
  end
  // --------------------------------------------------------------
  // Bus cycles
  // --------------------------------------------------------------
  // Quarter of a 160 ns bit; the clock stands high between frames
  task automatic q();
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task automatic st(input logic s1, input logic s2);
    sda_rel = s1;
    q();
    scl = 1'b1;
    q();
    sda_rel = s2;
    q();
  endtask
  task automatic start();
    st(1'b1, 1'b0);
    scl = 1'b0;
    q();
  endtask
  // Data only moves while the clock is low, so the device sees no false start
  task automatic bit_io(input logic b, output logic r);
    sda_rel = b;
    q();
    scl = 1'b1;
    q();
    r = sda;
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ack_in, input logic w,
                      output logic [7:0] rx);
    logic k;
    for (int i = 7; i >= 0; i--)
      bit_io(tx[i], rx[i]);
    bit_io(ack_in, k);
    if (w && k)
      naks++;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d);
    logic [7:0] r;
    start();
    xfer({a, 1'b0}, 1'b1, 1'b1, r);
    xfer(p, 1'b1, 1'b1, r);
    xfer(d[15:8] & 8'h7d, 1'b1, 1'b1, r);
    xfer(d[7:0], 1'b1, 1'b1, r);
    st(1'b0, 1'b1);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [15:0] d);
    logic [7:0] r;
    start();
    xfer({a, 1'b0}, 1'b1, 1'b1, r);
    xfer(p, 1'b1, 1'b1, r);
    start();
    xfer({a, 1'b1}, 1'b1, 1'b1, r);
    xfer(8'hff, 1'b0, 1'b0, d[15:8]);
    xfer(8'hff, 1'b1, 1'b0, d[7:0]);
    st(1'b0, 1'b1);
  endtask
endmodule
`default_nettype wire

// ---- sim/srp_status_assertions.sv ----
// Concurrent checks on the top-level pins of the status register block.
// Assumes one core clock domain and pin inputs held steady around low-power exit.
`timescale 1ns/100ps
`default_nettype none

module srp_status_assertions
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic scl_pin,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic mfp_out,
  input wire logic mfp_oe_n,
  input wire logic mfp_ready_cfg,
  input wire logic addr_strap_pin,
  input wire logic clk_ready,
  input wire logic all_outputs_disabled,
  input wire logic outputs_mute,
  input wire logic low_power,
  input wire logic fuse_config_mode,
  input wire logic [1:0] resampled_select
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // --------------------------------------------------------------
  // Pin relations
  // --------------------------------------------------------------
  a_mfp_mirror: assert property (!mfp_oe_n |-> mfp_out == $past(clk_ready))
    else $error("mfp pin does not mirror clock ready");
  a_mfp_enable: assert property ($past(arst_n) |-> mfp_oe_n == !$past(mfp_ready_cfg))
    else $error("mfp enable does not follow its configuration");
  a_mute_follows: assert property ($past(arst_n) |->
    outputs_mute == $past(all_outputs_disabled))
    else $error("mute does not follow outputs disabled");
  a_sleep_muted: assert property ($rose(low_power) && $past(all_outputs_disabled) |->
    outputs_mute)
    else $error("idle low power without mute");
  // Data may only move a few cycles after the serial clock fell
  a_sda_low_phase: assert property ($changed(sda_oe_n) |-> !$past(scl_pin, 3))
    else $error("data pin moved while serial clock high");
  a_open_drain: assert property (!sda_oe_n |-> sda_out == 1'b0)
    else $error("data pin driven high");
  a_mode_resample: assert property ($changed(fuse_config_mode) |->
    $fell(low_power) && fuse_config_mode == addr_strap_pin)
    else $error("mode changed outside a strap resample");
  a_select_resample: assert property ($changed(resampled_select) |-> $fell(low_power))
    else $error("select pins captured outside low-power exit");
endmodule

bind srp_i2c_status_top srp_status_assertions i_chk (.core_clk, .arst_n, .scl_pin, .sda_out,
  .sda_oe_n, .mfp_out, .mfp_oe_n, .mfp_ready_cfg, .addr_strap_pin, .clk_ready,
  .all_outputs_disabled, .outputs_mute, .low_power, .fuse_config_mode, .resampled_select);
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench for the status, readback and idle-power register block.
// Assumes the host model and the checker file are compiled ahead of it.
`timescale 1ns/100ps
`default_nettype none

`define CHK(a, e, m) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; $display("mismatch %0t %s got %h", $time, m, a); end end

module testbench
  import srp_pkg::*;
;
  logic core_clk, arst_n, clk_ready, mfp_in, mfp_ready_cfg, strap, aod, fuse_idle;
  logic scl, sda_rel, sda_out, sda_oe_n, mfp_out, mfp_oe_n, mute, lp, fcm;
  logic [1:0] rsel;
  logic [15:0] d;
  int n_mismatch = 0;
  int n_compared = 0;
  wire sda;
  // Open-drain wire with pull-up: low if either party pulls
  assign sda = sda_rel & (sda_oe_n | sda_out);
  srp_i2c_status_top i_dut (.core_clk, .arst_n, .scl_pin(scl), .sda_in(sda), .sda_out,
    .sda_oe_n, .mfp_in, .mfp_out, .mfp_oe_n, .mfp_ready_cfg, .addr_strap_pin(strap),
    .clk_ready, .all_outputs_disabled(aod), .fuse_idle_select(fuse_idle), .outputs_mute(mute),
    .low_power(lp), .fuse_config_mode(fcm), .resampled_select(rsel));
  srp_i2c_host i_host (.core_clk, .sda, .scl, .sda_rel);
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Bits 7:6 show live bus activity during the read itself, so they are masked
  task automatic chk_reg(input logic [15:0] e);
    i_host.rd(SRP_DEV_ADDR_RESET, SRP_REG_ADDR, d);
    `CHK(d & 16'hff3f, e, "register")
  endtask
  task automatic wr(input logic [15:0] v);
    i_host.wr(SRP_DEV_ADDR_RESET, SRP_REG_ADDR, v);
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset();
    chk_reg(SRP_REG_RESET);
    `CHK(({mute, lp, fcm, rsel}), 5'h00, "reset outputs")
    arst_n = 1'b0;
    fuse_idle = 1'b0;
    cyc(2);
    arst_n = 1'b1;
    cyc(3);
    chk_reg(16'h0000);
  endtask
  task automatic t_readback();
    clk_ready = 1'b1;
    mfp_in = 1'b1;
    strap = 1'b1;
    mfp_ready_cfg = 1'b1;
    cyc(3);
    `CHK(({mfp_oe_n, mfp_out}), 2'b01, "mfp mirror")
    chk_reg(16'h0520);
    // Ones aimed at the read-only bits must not stick
    wr(16'h05e0);
    clk_ready = 1'b0;
    cyc(3);
    `CHK(mfp_out, 1'b0, "mfp follows")
    chk_reg(16'h0120);
  endtask
  task automatic t_idle_sleep();
    // Data line held low over the exit so the capture differs from the idle level
    i_host.sda_rel = 1'b0;
    aod = 1'b1;
    cyc(2);
    `CHK(({mute, lp}), 2'b11, "mute and sleep")
    aod = 1'b0;
    cyc(2);
    `CHK(({lp, fcm, rsel}), 4'b0101, "resample on exit")
    i_host.sda_rel = 1'b1;
    cyc(3);
  endtask
  task automatic t_power_down();
    wr(16'h0010);
    aod = 1'b1;
    cyc(2);
    `CHK(({mute, lp}), 2'b10, "mute only")
    aod = 1'b0;
    wr(16'h0012);
    `CHK(lp, 1'b1, "power down")
    wr(16'h001a);
    strap = 1'b0;
    wr(16'h0018);
    `CHK(({lp, fcm, rsel}), 4'b0101, "no resample")
    chk_reg(16'h0118);
  endtask
  task automatic t_refused();
    i_host.naks = 0;
    i_host.wr(SRP_DEV_ADDR_RESET ^ 7'h01, SRP_REG_ADDR, 16'h0000);
    `CHK(i_host.naks, 4, "foreign address")
    i_host.wr(SRP_DEV_ADDR_RESET, 8'h0b, 16'h0000);
    i_host.rd(SRP_DEV_ADDR_RESET, 8'h0b, d);
    `CHK(d, 16'h0000, "other pointer")
    chk_reg(16'h0118);
  endtask
  initial
  begin
    arst_n = 1'b0;
    clk_ready = 1'b0;
    mfp_in = 1'b0;
    mfp_ready_cfg = 1'b0;
    strap = 1'b0;
    aod = 1'b0;
    fuse_idle = 1'b1;
    cyc(5);
    arst_n = 1'b1;
    cyc(3);
    t_reset();
    t_readback();
    t_idle_sleep();
    t_power_down();
    t_refused();
    results();
  end
  // Whole run needs about 96 us; over three times that means a hang
  initial
  begin
    #300000;
    n_mismatch++;
    results();
  end
endmodule
`default_nettype wire
